// file: hdl/sfep_pkg.sv
// Shared constants and types for the serial flash erase/program/protect sequencer.
// Assumes a core clock of 25 MHz and a serial link clocked by the host.
package sfep_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int unsigned CLK_FREQ_MHZ = 25;          // Core clock rate, cycles per microsecond
  localparam int unsigned TIMER_W      = 32;          // Width of the self-timed operation counter

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0]  OPC_SECTOR_ERASE = 8'h7C;
  localparam logic [7:0]  OPC_PAGE_PROG    = 8'h82;
  localparam logic [31:0] SEQ_CHIP_ERASE   = 32'hC794_809A;
  localparam logic [31:0] SEQ_PROT_ENABLE  = 32'h3D2A_7FA9;
  localparam logic [31:0] SEQ_PROT_DISABLE = 32'h3D2A_7F9A;

  // ************************************************************
  // Frame and address layout
  // ************************************************************
  localparam int unsigned BYTE_W        = 8;
  localparam logic [2:0]  CMD_BYTES     = 3'h4;         // Opcode plus three address bytes
  localparam logic [2:0]  ADDR_LAST_IDX = 3'h3;         // Count at which the last address byte lands
  localparam logic [2:0]  BIT_LAST      = 3'h7;         // Last bit of a byte on the link
  localparam int unsigned OPC_LSB       = 24;
  localparam int unsigned PAGE_W        = 10;
  localparam int unsigned STD_PAGE_LSB  = 9;            // page_addr 9..0 sits above 9 buffer bits
  localparam int unsigned BIN_PAGE_LSB  = 8;            // binary_addr 17..8
  localparam int unsigned BUF_AW        = 9;
  localparam logic [8:0]  BUF_LAST_STD  = 9'h107;       // 264-byte buffer
  localparam logic [8:0]  BUF_LAST_BIN  = 9'h0FF;       // 256-byte buffer
  localparam logic [8:0]  BUF_FIRST     = 9'h000;

  // ************************************************************
  // Sectors and protection map
  // ************************************************************
  localparam int unsigned SECT_N      = 9;              // 0a, 0b, then 1 to 7
  localparam int unsigned SECT_IDX_W  = 4;
  localparam logic [3:0]  SECT_0A     = 4'h0;
  localparam logic [3:0]  SECT_0B     = 4'h1;
  localparam int unsigned PMAP_W      = 64;             // One byte per sector 0 to 7
  localparam int unsigned PMAP_0A_HI  = 7;
  localparam int unsigned PMAP_0A_LO  = 6;
  localparam int unsigned PMAP_0B_HI  = 5;
  localparam int unsigned PMAP_0B_LO  = 4;
  localparam int unsigned PG_SECT_LSB = 7;              // page_addr 9..7 picks sectors 1 to 7
  localparam int unsigned PG_0B_BIT   = 3;              // page_addr 6..3 splits 0a from 0b

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    OP_NONE   = 2'b00,
    OP_SECTOR = 2'b01,
    OP_CHIP   = 2'b10,
    OP_PAGE   = 2'b11
  } sfep_op_kind_t;

  typedef struct packed {
    sfep_op_kind_t       kind;
    logic [SECT_N-1:0]   sectors;                       // Sectors really erased by this operation
    logic [PAGE_W-1:0]   page;                          // Target page for a page program
  } sfep_op_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ERASE  = 2'b01,
    ST_STREAM = 2'b10
  } sfep_state_t;

endpackage : sfep_pkg

// file: hdl/sfep_buf_mem.sv
// Data buffer of the sequencer: one write port, one registered read port.
// Assumes both ports run on the core clock and addresses stay below the depth.
`timescale 1ns/100ps
module sfep_buf_mem (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [8:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [8:0] rd_addr,
  output logic      [7:0] rd_data
);

  // ************************************************************
  // Storage
  // ************************************************************
  localparam int unsigned DEPTH = 264;

  logic [7:0] mem [DEPTH];
  logic [7:0] rd_data_reg;

  // Write port; the array has no reset, like the real SRAM
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data always leaves through a register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_reg;

endmodule : sfep_buf_mem

// file: hdl/sfep_sequencer.sv
// Command decoder and self-timed sequencer for sector erase, chip erase,
// page program through the buffer and software sector protection.
// Assumes a host in SPI mode 0 or 3 on sck/cs_n/si, and that the flash
// array itself sits outside, driven by the op and program stream outputs.
// Functional notes
// - Standard 0a/0b erase uses page bits 9..3
// - Standard sector 1-7 erase uses bits 9..7
// - Binary 0a/0b erase uses address bits 17..11
// - Binary sector 1-7 erase uses bits 17..15
// - Any page in sector selects it; 0a/0b split
// - One sector erased per sector-erase command
// - Chip select rise starts timed sector erase
// - Chip erase: four bytes, extra bytes ignored
// - Chip select rise starts timed full erase
// - Chip erase skips protected and locked sectors
// - Write-protect takes effect after erase completes
// - Standard program: page 9..0, buffer byte 8..0
// - Binary program: address 17..8, buffer byte 7..0
// - Data bytes fill buffer, incrementing, wrapping
// - Chip select rise: erase page, then program
// - Map-protected sectors blocked only while enabled
// - Enable sequence sets protection at frame end
// - Disable sequence clears protection at frame end
// - Disable ignored while write-protect asserted
// - Write-protect input pulled high when floating
// - Software protection starts disabled after power-up
// - Status shows protection enabled by either method
// - Write-protect asserted alone enables protection
// - Map byte all ones protects its sector
`timescale 1ns/100ps
module sfep_sequencer #(
  parameter int unsigned SECTOR_ERASE_TIME_US   = 1000,
  parameter int unsigned FULL_ERASE_TIME_US     = 8000,
  parameter int unsigned ERASE_PROGRAM_TIME_US  = 40
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             sck,
  input  wire logic             cs_n,
  input  wire logic             si,
  input  wire logic             wp_n,
  input  wire logic             binary_page_mode,
  input  wire logic [63:0]      prot_map,
  input  wire logic [8:0]       lockdown,
  output logic                  busy,
  output logic                  prot_enabled,
  output logic                  sw_prot,
  output logic                  op_valid,
  output sfep_pkg::sfep_op_t    op,
  output logic                  prog_valid,
  output logic [7:0]            prog_byte,
  output logic [8:0]            prog_index
);

  // ************************************************************
  // Timing counts
  // ************************************************************
  // Counts are exact multiples of the core rate; at least one cycle each
  localparam int unsigned SE_CYC_RAW = SECTOR_ERASE_TIME_US * sfep_pkg::CLK_FREQ_MHZ;
  localparam int unsigned FE_CYC_RAW = FULL_ERASE_TIME_US * sfep_pkg::CLK_FREQ_MHZ;
  localparam int unsigned EP_CYC_RAW = ERASE_PROGRAM_TIME_US * sfep_pkg::CLK_FREQ_MHZ;
  localparam logic [31:0] SE_CYC     = (SE_CYC_RAW < 1) ? 32'h0000_0001 : 32'(SE_CYC_RAW);
  localparam logic [31:0] FE_CYC     = (FE_CYC_RAW < 1) ? 32'h0000_0001 : 32'(FE_CYC_RAW);
  localparam logic [31:0] EP_CYC     = (EP_CYC_RAW < 1) ? 32'h0000_0001 : 32'(EP_CYC_RAW);
  localparam logic [31:0] TIMER_DONE = 32'h0000_0001;

  // ************************************************************
  // Functions
  // ************************************************************
  // Page number from the three address bytes, per page-size mode
  function automatic logic [9:0] page_of(input logic [23:0] addr, input logic bin);
    return bin ? addr[sfep_pkg::BIN_PAGE_LSB +: sfep_pkg::PAGE_W]
               : addr[sfep_pkg::STD_PAGE_LSB +: sfep_pkg::PAGE_W];
  endfunction : page_of

  // Sector index 0=0a, 1=0b, k+1 for sectors 1..7; low page bits never matter
  function automatic logic [3:0] sector_of(input logic [9:0] pg);
    return (pg[9:sfep_pkg::PG_SECT_LSB] != 3'h0)
           ? 4'({1'b0, pg[9:sfep_pkg::PG_SECT_LSB]}) + sfep_pkg::SECT_0B
           : (pg[9:sfep_pkg::PG_0B_BIT] == 7'h00) ? sfep_pkg::SECT_0A : sfep_pkg::SECT_0B;
  endfunction : sector_of

  // Whether the map marks one sector for protection
  function automatic logic map_protects(input logic [63:0] map, input logic [3:0] sid);
    return (sid == sfep_pkg::SECT_0A) ? map[sfep_pkg::PMAP_0A_HI] & map[sfep_pkg::PMAP_0A_LO]
         : (sid == sfep_pkg::SECT_0B) ? map[sfep_pkg::PMAP_0B_HI] & map[sfep_pkg::PMAP_0B_LO]
         : &map[(sid - sfep_pkg::SECT_0B) * sfep_pkg::BYTE_W +: sfep_pkg::BYTE_W];
  endfunction : map_protects

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_pipe_reg;
  logic       rst_n;

  // Two stages so that every core flop leaves reset on the same edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe_reg <= 2'b00;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_reg[1];

  // ************************************************************
  // Link domain (sck)
  // ************************************************************
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic [7:0] byte_hold_reg;
  logic       byte_tog_reg;

  // Bit counter and shifter restart with each frame, since sck may stop between frames
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 7'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg   <= {shift_reg[5:0], si};
    end
  end

  // Whole byte is held stable for eight sck periods while its toggle crosses over
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      byte_hold_reg <= 8'h00;
      byte_tog_reg  <= 1'b0;
    end else if (!cs_n && bit_cnt_reg == sfep_pkg::BIT_LAST) begin
      byte_hold_reg <= {shift_reg, si};
      byte_tog_reg  <= ~byte_tog_reg;
    end
  end

  // ************************************************************
  // Crossings into the core domain
  // ************************************************************
  logic [4:0] cs_pipe_reg;
  logic [2:0] tog_pipe_reg;
  logic [1:0] wp_pipe_reg;
  logic       cs_fall;
  logic       cs_rise;
  logic       byte_evt;
  logic       wp_on;

  // Frame end is seen two cycles after the last byte toggle can have settled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_pipe_reg  <= 5'h1F;
      tog_pipe_reg <= 3'h0;
      wp_pipe_reg  <= 2'b11;
    end else begin
      cs_pipe_reg  <= {cs_pipe_reg[3:0], cs_n};
      tog_pipe_reg <= {tog_pipe_reg[1:0], byte_tog_reg};
      wp_pipe_reg  <= {wp_pipe_reg[0], wp_n};
    end
  end

  assign cs_fall  = cs_pipe_reg[2] & ~cs_pipe_reg[1];
  assign cs_rise  = ~cs_pipe_reg[4] & cs_pipe_reg[3];
  assign byte_evt = tog_pipe_reg[2] ^ tog_pipe_reg[1];
  assign wp_on    = ~wp_pipe_reg[1];          // A floating pin reads high at the pad

  // ************************************************************
  // Frame parsing
  // ************************************************************
  sfep_pkg::sfep_state_t state_reg;
  sfep_pkg::sfep_state_t state_next;
  logic [2:0]            byte_cnt_reg;
  logic [31:0]           cmd_reg;
  logic                  frame_ok_reg;
  logic [8:0]            wr_ptr_reg;
  logic                  idle;
  logic                  take_hdr;
  logic                  is_prog_data;
  logic                  at_last_addr;
  logic [8:0]            buf_last;
  logic [8:0]            start_ptr;
  logic [8:0]            wr_ptr_inc;

  assign idle         = (state_reg == sfep_pkg::ST_IDLE);
  assign take_hdr     = byte_evt & frame_ok_reg & (byte_cnt_reg < sfep_pkg::CMD_BYTES);
  assign at_last_addr = take_hdr & (byte_cnt_reg == sfep_pkg::ADDR_LAST_IDX);
  assign is_prog_data = byte_evt & frame_ok_reg & (byte_cnt_reg == sfep_pkg::CMD_BYTES)
                        & (cmd_reg[sfep_pkg::OPC_LSB +: sfep_pkg::BYTE_W] == sfep_pkg::OPC_PAGE_PROG);
  assign buf_last     = binary_page_mode ? sfep_pkg::BUF_LAST_BIN : sfep_pkg::BUF_LAST_STD;
  // Buffer start: 9 bits in standard mode, 8 bits in binary mode
  assign start_ptr    = binary_page_mode ? {1'b0, byte_hold_reg} : {cmd_reg[0], byte_hold_reg};
  assign wr_ptr_inc   = (wr_ptr_reg == buf_last) ? sfep_pkg::BUF_FIRST : wr_ptr_reg + 9'h001;

  // Header collects only the first four bytes; later bytes never alter it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt_reg <= 3'h0;
      cmd_reg      <= 32'h0000_0000;
      frame_ok_reg <= 1'b0;
    end else if (cs_fall) begin
      byte_cnt_reg <= 3'h0;
      cmd_reg      <= 32'h0000_0000;
      frame_ok_reg <= idle;                   // Frames that open while busy are dropped whole
    end else if (take_hdr) begin
      byte_cnt_reg <= byte_cnt_reg + 3'h1;
      cmd_reg      <= {cmd_reg[23:0], byte_hold_reg};
    end
  end

  // Buffer write pointer: loaded from the last address byte, then steps and wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= sfep_pkg::BUF_FIRST;
    end else if (at_last_addr) begin
      wr_ptr_reg <= start_ptr;
    end else if (is_prog_data) begin
      wr_ptr_reg <= wr_ptr_inc;
    end
  end

  // ************************************************************
  // Command decode and protection state
  // ************************************************************
  logic [7:0]  opcode;
  logic [9:0]  cmd_page;
  logic [3:0]  cmd_sector;
  logic        prot_on;
  logic        cmd_complete;
  logic        cmd_blocked;
  logic [8:0]  cmd_sector_bit;
  logic [8:0]  erasable_mask;
  logic        go_sector;
  logic        go_chip;
  logic        go_page;
  logic        go_enable;
  logic        go_disable;
  logic        sw_prot_reg;
  logic        hw_prot_reg;
  logic        prot_enabled_reg;

  // Sectors that neither protection nor lockdown keep out of a chip erase
  function automatic logic [8:0] erasable(input logic [63:0] map, input logic [8:0] lock, input logic en);
    logic [8:0] m;
    m = 9'h000;
    for (int i = 0; i < sfep_pkg::SECT_N; i++) begin
      m[i] = ~lock[i] & ~(en & map_protects(map, 4'(i)));
    end
    return m;
  endfunction : erasable

  assign opcode         = cmd_reg[sfep_pkg::OPC_LSB +: sfep_pkg::BYTE_W];
  assign cmd_page       = page_of(cmd_reg[23:0], binary_page_mode);
  assign cmd_sector     = sector_of(cmd_page);
  assign cmd_sector_bit = 9'h001 << cmd_sector;
  assign prot_on        = prot_enabled_reg;
  // A frame ending early has fewer than four bytes and does nothing
  assign cmd_complete   = cs_rise & frame_ok_reg & idle & (byte_cnt_reg == sfep_pkg::CMD_BYTES);
  assign cmd_blocked    = (prot_on & map_protects(prot_map, cmd_sector)) | lockdown[cmd_sector];
  assign erasable_mask  = erasable(prot_map, lockdown, prot_on);
  assign go_sector      = cmd_complete & (opcode == sfep_pkg::OPC_SECTOR_ERASE) & ~cmd_blocked;
  assign go_page        = cmd_complete & (opcode == sfep_pkg::OPC_PAGE_PROG) & ~cmd_blocked;
  assign go_chip        = cmd_complete & (cmd_reg == sfep_pkg::SEQ_CHIP_ERASE);
  assign go_enable      = cmd_complete & (cmd_reg == sfep_pkg::SEQ_PROT_ENABLE);
  assign go_disable     = cmd_complete & (cmd_reg == sfep_pkg::SEQ_PROT_DISABLE) & ~wp_on;

  // Software flag starts cleared; the pin copy only moves while the sequencer is idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_prot_reg      <= 1'b0;
      hw_prot_reg      <= 1'b0;
      prot_enabled_reg <= 1'b0;
    end else begin
      if (go_enable) begin
        sw_prot_reg <= 1'b1;
      end else if (go_disable) begin
        sw_prot_reg <= 1'b0;
      end
      if (idle) begin
        hw_prot_reg <= wp_on;
      end
      prot_enabled_reg <= sw_prot_reg | hw_prot_reg;
    end
  end

  // ************************************************************
  // Self-timed sequencer
  // ************************************************************
  logic [31:0]          timer_reg;
  logic [8:0]           rd_idx_reg;
  sfep_pkg::sfep_op_t   op_reg;
  logic                 op_valid_reg;
  logic                 busy_reg;
  logic                 prog_valid_reg;
  logic [8:0]           prog_index_reg;
  logic                 timer_end;
  logic                 stream_end;

  assign timer_end  = (timer_reg == TIMER_DONE);
  assign stream_end = (rd_idx_reg == buf_last);

  // Next state; page program erases first, then streams the buffer out
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sfep_pkg::ST_IDLE: begin
        if (go_sector || go_chip || go_page) begin
          state_next = sfep_pkg::ST_ERASE;
        end
      end
      sfep_pkg::ST_ERASE: begin
        if (timer_end) begin
          state_next = (op_reg.kind == sfep_pkg::OP_PAGE) ? sfep_pkg::ST_STREAM : sfep_pkg::ST_IDLE;
        end
      end
      sfep_pkg::ST_STREAM: begin
        if (stream_end) begin
          state_next = sfep_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = sfep_pkg::ST_IDLE;
      end
    endcase
  end

  // State, busy flag and erase timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sfep_pkg::ST_IDLE;
      busy_reg  <= 1'b0;
      timer_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      busy_reg  <= (state_next != sfep_pkg::ST_IDLE);
      if (go_sector) begin
        timer_reg <= SE_CYC;
      end else if (go_chip) begin
        timer_reg <= FE_CYC;
      end else if (go_page) begin
        timer_reg <= EP_CYC;
      end else if (state_reg == sfep_pkg::ST_ERASE) begin
        timer_reg <= timer_reg - 32'h0000_0001;
      end
    end
  end

  // Operation descriptor, pulsed once as each operation starts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_reg       <= '0;
      op_valid_reg <= 1'b0;
    end else begin
      op_valid_reg <= go_sector | go_chip | go_page;
      if (go_sector) begin
        op_reg <= '{kind: sfep_pkg::OP_SECTOR, sectors: cmd_sector_bit, page: cmd_page};
      end else if (go_chip) begin
        op_reg <= '{kind: sfep_pkg::OP_CHIP, sectors: erasable_mask, page: 10'h000};
      end else if (go_page) begin
        op_reg <= '{kind: sfep_pkg::OP_PAGE, sectors: 9'h000, page: cmd_page};
      end
    end
  end

  // Buffer read-out; valid lags the address by the memory's read register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_idx_reg     <= sfep_pkg::BUF_FIRST;
      prog_valid_reg <= 1'b0;
      prog_index_reg <= sfep_pkg::BUF_FIRST;
    end else begin
      prog_valid_reg <= (state_reg == sfep_pkg::ST_STREAM);
      prog_index_reg <= rd_idx_reg;
      if (state_reg == sfep_pkg::ST_STREAM && !stream_end) begin   // Never reads past the buffer end
        rd_idx_reg <= rd_idx_reg + 9'h001;
      end else begin
        rd_idx_reg <= sfep_pkg::BUF_FIRST;
      end
    end
  end

  // ************************************************************
  // Buffer memory and outputs
  // ************************************************************
  sfep_buf_mem u_buf (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (is_prog_data),
    .wr_addr (wr_ptr_reg),
    .wr_data (byte_hold_reg),
    .rd_addr (rd_idx_reg),
    .rd_data (prog_byte)
  );

  // Outputs come straight from their registers
  assign busy         = busy_reg;
  assign prot_enabled = prot_enabled_reg;
  assign sw_prot      = sw_prot_reg;
  assign op_valid     = op_valid_reg;
  assign op           = op_reg;
  assign prog_valid   = prog_valid_reg;
  assign prog_index   = prog_index_reg;

endmodule : sfep_sequencer

// file: tb/sfep_checker.sv
// Checker: port-level assertions on the sequencer.
// Assumes it is bound to sfep_sequencer, one core clock domain.
`timescale 1ns/100ps
module sfep_checker (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic               cs_n,
  input wire logic [8:0]         lockdown,
  input wire logic               busy,
  input wire logic               prot_enabled,
  input wire logic               sw_prot,
  input wire logic               op_valid,
  input wire sfep_pkg::sfep_op_t op,
  input wire logic               prog_valid,
  input wire logic [8:0]         prog_index
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_opv_one_cycle: assert property (op_valid |=> !op_valid) else $error("op_valid long");
  a_opv_busy: assert property (op_valid |-> busy && cs_n) else $error("op without busy");
  a_busy_needs_op: assert property ($rose(busy) |-> op_valid) else $error("busy without op");
  a_sect_onehot: assert property (op_valid && op.kind == sfep_pkg::OP_SECTOR |-> $onehot(op.sectors))
    else $error("sector set");
  a_chip_lock: assert property (op_valid && op.kind == sfep_pkg::OP_CHIP
    |-> (op.sectors & lockdown) == 9'h000) else $error("locked erased");
  a_prot_follow: assert property (sw_prot |=> prot_enabled) else $error("status lost");
  a_sw_frame_end: assert property ($changed(sw_prot) |-> cs_n && !busy)
    else $error("sw_prot early");
  a_prog_order: assert property (prog_valid && prog_index != 9'h000 |-> $past(prog_valid)
    && $past(prog_index) + 9'h001 == prog_index && op.kind == sfep_pkg::OP_PAGE) else $error("stream order");
  // Main scenarios reached
  c_sect: cover property (op_valid && op.kind == sfep_pkg::OP_SECTOR);
  c_chip: cover property (op_valid && op.kind == sfep_pkg::OP_CHIP);
  c_page: cover property (prog_valid && prog_index == 9'h107);
endmodule : sfep_checker
bind sfep_sequencer sfep_checker u_chk (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .lockdown(lockdown),
  .busy(busy), .prot_enabled(prot_enabled), .sw_prot(sw_prot), .op_valid(op_valid), .op(op),
  .prog_valid(prog_valid), .prog_index(prog_index));

// file: tb/sfep_host.sv
// Host serial controller model: frames bytes on cs_n/sck/si, MSB first.
// Assumes the caller leaves at least 8 core clocks between frames.
`timescale 1ns/100ps
module sfep_host (
  output logic sck,
  output logic cs_n,
  output logic si
);
  // Idle: link clock parked low, device deselected
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Top n bytes of d at a 48 ns link period; data inverted after release
  task automatic frame(input logic [63:0] d, input int n);
    int i;
    cs_n = 1'b0;
    for (i = 63; i > 63 - 8 * n; i--) begin
      si = d[i];
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
    #24 cs_n = 1'b1;
    si = ~si;
  endtask : frame
endmodule : sfep_host

// file: tb/serial_flash_erase_program_protect_test.sv
// Testbench: drives the sequencer through the host model and judges its ports.
// Assumes timed operations shortened to 25 core cycles.
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("MISMATCH %0t got %h", $time, a); end end
module serial_flash_erase_program_protect_test;
  logic clk = 1'b0, reset_n = 1'b0, wp_n = 1'b1, binary_page_mode = 1'b0;
  logic [63:0] prot_map = 64'h0000_0000_00FF_0000;
  logic [8:0] lockdown = 9'h000, prog_index;
  logic sck, cs_n, si, busy, prot_enabled, sw_prot, op_valid, prog_valid;
  logic [7:0] prog_byte, b_first, b_last;
  sfep_pkg::sfep_op_t op;
  int errors = 0, compares = 0, cyc = 0, nprog = 0;
  always #20 clk = ~clk;
  sfep_host HOST (.sck(sck), .cs_n(cs_n), .si(si));
  sfep_sequencer #(.SECTOR_ERASE_TIME_US(1), .FULL_ERASE_TIME_US(1), .ERASE_PROGRAM_TIME_US(1)) DUT (
    .clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .binary_page_mode(binary_page_mode), .prot_map(prot_map), .lockdown(lockdown), .busy(busy),
    .prot_enabled(prot_enabled), .sw_prot(sw_prot), .op_valid(op_valid), .op(op),
    .prog_valid(prog_valid), .prog_byte(prog_byte), .prog_index(prog_index));
  // Stream monitor and hang guard
  always @(negedge clk) if (prog_valid === 1'b1) begin
    nprog++;
    if (prog_index === 9'h000) b_first = prog_byte;
    if (prog_index === 9'h107) b_last = prog_byte;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      test_done();
    end
  end
  // One frame, then expected op kind k and erase set s; waits out busy
  task automatic run(input logic [63:0] d, input int n, input logic [1:0] k, input logic [8:0] s);
    int i;
    HOST.frame(d, n);
    for (i = 0; i < 20 && op_valid !== 1'b1; i++) @(negedge clk);
    `CHK(op_valid, k != 2'b00)
    if (k != 2'b00) `CHK(op.kind, k)
    if (k == sfep_pkg::OP_SECTOR || k == sfep_pkg::OP_CHIP) `CHK(op.sectors, s)
    for (i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clk);
    repeat (3) @(negedge clk);
    `CHK(busy, 1'b0)
  endtask : run
  task automatic t_sector;
    run({8'h7C, 24'h00_1000, 32'h0}, 4, 2'b01, 9'h002);
    run({8'h7C, 24'h07_0000, 32'h0}, 4, 2'b01, 9'h100);
    @(posedge clk) binary_page_mode <= 1'b1;
    run({8'h7C, 24'h00_0000, 32'h0}, 4, 2'b01, 9'h001);
    run({8'h7C, 24'h02_8000, 32'h0}, 4, 2'b01, 9'h040);
    @(posedge clk) binary_page_mode <= 1'b0;
    run({8'h7C, 16'h0000, 40'h0}, 3, 2'b00, 9'h000);
  endtask : t_sector
  task automatic t_prot;
    run({sfep_pkg::SEQ_PROT_ENABLE, 32'h0}, 4, 2'b00, 9'h000);
    `CHK({sw_prot, prot_enabled}, 2'b11)
    run({8'h7C, 24'h02_0000, 32'h0}, 4, 2'b00, 9'h000);
    @(posedge clk) wp_n <= 1'b0;
    run({sfep_pkg::SEQ_PROT_DISABLE, 32'h0}, 4, 2'b00, 9'h000);
    `CHK(sw_prot, 1'b1)
    @(posedge clk) wp_n <= 1'b1;
    run({sfep_pkg::SEQ_PROT_DISABLE, 32'h0}, 4, 2'b00, 9'h000);
    `CHK({sw_prot, prot_enabled}, 2'b00)
    run({8'h7C, 24'h02_0000, 32'h0}, 4, 2'b01, 9'h008);
  endtask : t_prot
  task automatic t_wp;
    @(posedge clk) wp_n <= 1'b0;
    repeat (8) @(negedge clk);
    `CHK({sw_prot, prot_enabled}, 2'b01)
    @(posedge clk) wp_n <= 1'b1;
    repeat (8) @(negedge clk);
    `CHK(prot_enabled, 1'b0)
  endtask : t_wp
  task automatic t_chip_page;
    @(posedge clk) lockdown <= 9'h004;
    run({sfep_pkg::SEQ_CHIP_ERASE, 8'h55, 24'h0}, 5, 2'b10, 9'h1FB);
    @(posedge clk) lockdown <= 9'h000;
    run({8'h82, 24'h00_0B07, 8'hAA, 8'h55, 16'h0}, 6, 2'b11, 9'h000);
    `CHK(op.page, 10'h005)
    `CHK({b_last, b_first}, 16'hAA55)
    `CHK(nprog, 264)
  endtask : t_chip_page
  task automatic test_done;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(negedge clk);
    `CHK(sw_prot, 1'b0)
    t_sector();
    t_prot();
    t_wp();
    t_chip_page();
    test_done();
  end
endmodule : serial_flash_erase_program_protect_test
